// ---- hw/bss_params.svh ----
// Constants for the battery switch, ship mode and status control block
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH
`define BSS_CLK_HZ 200000000
// Times in milliseconds or microseconds as specified
`define BSS_SHIP_DLY_MS 12500
`define BSS_QON_DEGLITCH_MS 1000
`define BSS_QON_RST_MS 10000
`define BSS_SWITCH_RST_MS 250
`define BSS_IRQ_PULSE_US 256
`define BSS_BLINK_HALF_MS 500
// Derived cycle counts (all exact at 200 MHz)
`define BSS_CYC_PER_MS (`BSS_CLK_HZ / 1000)
`define BSS_CYC_PER_US (`BSS_CLK_HZ / 1000000)
`define BSS_SHIP_DLY_CYC (`BSS_SHIP_DLY_MS * `BSS_CYC_PER_MS)
`define BSS_QON_DEGLITCH_CYC (`BSS_QON_DEGLITCH_MS * `BSS_CYC_PER_MS)
`define BSS_QON_RST_CYC (`BSS_QON_RST_MS * `BSS_CYC_PER_MS)
`define BSS_SWITCH_RST_CYC (`BSS_SWITCH_RST_MS * `BSS_CYC_PER_MS)
`define BSS_IRQ_PULSE_CYC (`BSS_IRQ_PULSE_US * `BSS_CYC_PER_US)
`define BSS_BLINK_HALF_CYC (`BSS_BLINK_HALF_MS * `BSS_CYC_PER_MS)
`define BSS_BOOST_RETRIES 3'h7
// Field codes
`define BSS_CHG_FAULT_NONE 2'h0
`define BSS_CHG_FAULT_INPUT 2'h1
`define BSS_IND_DISABLED 2'h3
`define BSS_OVP_DEFAULT 2'h3
`endif

// ---- hw/bss_pkg.sv ----
// Types shared by both ends of the battery switch control block
package bss_pkg;
    // Battery switch control states
    typedef enum logic [2:0] {
        BSS_ON,
        BSS_SHIP_WAIT,
        BSS_SHIP,
        BSS_RESET_OFF
    } bss_sw_state_t;
endpackage

// ---- hw/bss_if.sv ----
// Interface joining the charger control device and the host end
`timescale 1ns/1ps
interface bss_if;
    logic battery_switch_disable; // Host command bits
    logic ship_entry_delay_sel;
    logic switch_reset_enable;
    logic register_reset;
    logic input_highz_clear;
    logic boost_enable_req;
    logic boost_enable_clr_req;
    logic [1:0] input_overvoltage_sel;
    logic [1:0] charge_indicator_func_sel;
    logic fault_read;
    logic quick_on_button_n; // Push button level
    logic host_irq_n; // Device status
    logic power_good_flag;
    logic input_highz_enable;
    logic boost_output_enable;
    logic [7:0] fault_register;
    logic battery_switch_on;
    modport device (
        input battery_switch_disable, ship_entry_delay_sel, switch_reset_enable, register_reset,
        input input_highz_clear, boost_enable_req, boost_enable_clr_req, input_overvoltage_sel,
        input charge_indicator_func_sel, fault_read, quick_on_button_n,
        output host_irq_n, power_good_flag, input_highz_enable, boost_output_enable,
        output fault_register, battery_switch_on
    );
    modport host (
        output battery_switch_disable, ship_entry_delay_sel, switch_reset_enable, register_reset,
        output input_highz_clear, boost_enable_req, boost_enable_clr_req, input_overvoltage_sel,
        output charge_indicator_func_sel, fault_read, quick_on_button_n,
        input host_irq_n, power_good_flag, input_highz_enable, boost_output_enable,
        input fault_register, battery_switch_on
    );
endinterface

// ---- hw/bss_device.sv ----
// Device end: battery switch, ship mode, status and fault logic
`timescale 1ns/1ps
`include "bss_params.svh"
module bss_device (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Host side
    bss_if.device hif,
    // Analog comparator flags from the power stage
    input wire logic vbus_present,
    input wire logic vbus_in_range,
    input wire logic vbus_above_bat_sleep,
    input wire logic vbus_not_poor,
    input wire logic input_type_done,
    input wire logic input_overvoltage_raw,
    input wire logic system_overvoltage,
    input wire logic boost_short,
    input wire logic boost_retry_done,
    input wire logic charging,
    input wire logic charge_done,
    input wire logic limit_event,
    input wire logic limit_irq_mask,
    input wire logic [2:0] thermistor_fault_in,
    input wire logic other_fault,
    // Power stage controls
    output logic battery_switch_gate,
    output logic converter_stop,
    output logic sys_sink_enable,
    output logic stat_pin_o,
    output logic stat_pin_oe
);
    import bss_pkg::*;

    // ----------------------------------------
    // Quick-on pin synchroniser and timer
    // ----------------------------------------
    logic qon_s1_reg, qon_s2_reg; // Two-stage sync
    logic [31:0] qon_cnt_reg; // Low duration count
    logic qon_short_pulse; // Deglitch reached
    logic qon_long_press; // Reset press reached
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            qon_s1_reg <= 1'b1;
            qon_s2_reg <= 1'b1;
        end else begin
            qon_s1_reg <= hif.quick_on_button_n;
            qon_s2_reg <= qon_s1_reg;
        end
    end
    // Count low time, saturating past the long threshold
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            qon_cnt_reg <= 32'h0;
        end else if (qon_s2_reg) begin
            qon_cnt_reg <= 32'h0;
        end else if (qon_cnt_reg <= 32'(`BSS_QON_RST_CYC)) begin
            qon_cnt_reg <= qon_cnt_reg + 32'h1;
        end
    end
    assign qon_short_pulse = (qon_cnt_reg == 32'(`BSS_QON_DEGLITCH_CYC));
    assign qon_long_press = (qon_cnt_reg == 32'(`BSS_QON_RST_CYC));

    // ----------------------------------------
    // Battery switch state machine
    // ----------------------------------------
    bss_sw_state_t sw_state_reg;
    logic [31:0] sw_cnt_reg; // Delay and off-time count
    logic dis_prev_reg; // Edge detect of disable bit
    logic vbus_prev_reg; // Edge detect of input power arrival
    logic qon_exit; // Ship exit by button
    logic dis_rise;
    assign dis_rise = hif.battery_switch_disable && !dis_prev_reg;
    assign qon_exit = qon_short_pulse && (sw_state_reg == BSS_SHIP);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dis_prev_reg <= 1'b0;
            vbus_prev_reg <= 1'b0;
        end else begin
            dis_prev_reg <= hif.battery_switch_disable;
            vbus_prev_reg <= vbus_present;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_state_reg <= BSS_ON;
            sw_cnt_reg <= 32'h0;
        end else begin
            unique case (sw_state_reg)
                BSS_ON: begin
                    sw_cnt_reg <= 32'h0;
                    if (dis_rise) begin
                        // Immediate or delayed entry
                        sw_state_reg <= hif.ship_entry_delay_sel ? BSS_SHIP_WAIT : BSS_SHIP;
                    end else if (qon_long_press && !vbus_present && !hif.battery_switch_disable
                                 && hif.switch_reset_enable) begin
                        sw_state_reg <= BSS_RESET_OFF;
                    end
                end
                BSS_SHIP_WAIT: begin
                    if (!hif.battery_switch_disable || hif.register_reset) begin
                        sw_state_reg <= BSS_ON;
                    end else if (sw_cnt_reg == 32'(`BSS_SHIP_DLY_CYC - 1)) begin
                        sw_state_reg <= BSS_SHIP;
                    end else begin
                        sw_cnt_reg <= sw_cnt_reg + 32'h1;
                    end
                end
                BSS_SHIP: begin
                    // Exits: power arrives, button, clear or reset
                    if ((vbus_present && !vbus_prev_reg) || qon_short_pulse) begin
                        sw_state_reg <= BSS_ON;
                    end else if (!hif.battery_switch_disable || hif.register_reset) begin
                        sw_state_reg <= BSS_ON; // Also ends a host power cycle
                    end
                end
                BSS_RESET_OFF: begin
                    if (sw_cnt_reg == 32'(`BSS_SWITCH_RST_CYC - 1)) begin
                        sw_state_reg <= BSS_ON;
                    end else begin
                        sw_cnt_reg <= sw_cnt_reg + 32'h1;
                    end
                end
                default: sw_state_reg <= BSS_ON;
            endcase
        end
    end
    // Switch gate from state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            battery_switch_gate <= 1'b1;
            hif.battery_switch_on <= 1'b1;
        end else begin
            battery_switch_gate <= (sw_state_reg == BSS_ON) || (sw_state_reg == BSS_SHIP_WAIT);
            hif.battery_switch_on <= (sw_state_reg == BSS_ON) || (sw_state_reg == BSS_SHIP_WAIT);
        end
    end

    // ----------------------------------------
    // High-z and boost enable
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hif.input_highz_enable <= 1'b0;
        end else if (qon_exit) begin
            hif.input_highz_enable <= 1'b1; // Set wins over clear
        end else if (hif.input_highz_clear || hif.register_reset) begin
            hif.input_highz_enable <= 1'b0;
        end
    end
    logic boost_fault_reg; // Boost fault flag, held until the next boost enable request
    logic [2:0] retry_cnt_reg; // Hiccup retries seen while shorted
    logic boost_giveup; // Short outlived every retry
    assign boost_giveup = boost_short && hif.boost_output_enable && (retry_cnt_reg == `BSS_BOOST_RETRIES);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hif.boost_output_enable <= 1'b0;
        end else if (boost_giveup || hif.boost_enable_clr_req || hif.register_reset) begin
            hif.boost_output_enable <= 1'b0;
        end else if (hif.boost_enable_req && !hif.input_highz_enable) begin
            hif.boost_output_enable <= 1'b1;
        end
    end
    // Retry count from the hiccup logic: fault after seven
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retry_cnt_reg <= 3'h0;
        end else if (!boost_short || !hif.boost_output_enable) begin
            retry_cnt_reg <= 3'h0;
        end else if (boost_retry_done && retry_cnt_reg != `BSS_BOOST_RETRIES) begin
            retry_cnt_reg <= retry_cnt_reg + 3'h1;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boost_fault_reg <= 1'b0;
        end else if (boost_giveup) begin
            boost_fault_reg <= 1'b1;
        end else if (hif.boost_enable_req) begin
            boost_fault_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Protection and power good
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            converter_stop <= 1'b0;
            sys_sink_enable <= 1'b0;
            hif.power_good_flag <= 1'b0;
        end else begin
            converter_stop <= input_overvoltage_raw || system_overvoltage;
            sys_sink_enable <= system_overvoltage;
            hif.power_good_flag <= vbus_in_range && vbus_above_bat_sleep && vbus_not_poor
                                   && input_type_done;
        end
    end

    // ----------------------------------------
    // Fault register and interrupt
    // ----------------------------------------
    logic ovp_prev_reg, pg_prev_reg, done_prev_reg, type_prev_reg, lim_prev_reg, oth_prev_reg;
    logic chg_fault_reg; // Latched input overvoltage
    logic other_fault_reg;
    logic fault_pending_reg; // Unread fault history
    logic [31:0] irq_cnt_reg;
    logic fault_new, status_event;
    assign fault_new = (input_overvoltage_raw && !ovp_prev_reg) || boost_giveup || (other_fault && !oth_prev_reg);
    assign status_event = (charge_done && !done_prev_reg) || (input_type_done && !type_prev_reg)
                          || (hif.power_good_flag != pg_prev_reg)
                          || (limit_event && !lim_prev_reg && !limit_irq_mask);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovp_prev_reg <= 1'b0;
            pg_prev_reg <= 1'b0;
            done_prev_reg <= 1'b0;
            type_prev_reg <= 1'b0;
            lim_prev_reg <= 1'b0;
            oth_prev_reg <= 1'b0;
        end else begin
            ovp_prev_reg <= input_overvoltage_raw;
            pg_prev_reg <= hif.power_good_flag;
            done_prev_reg <= charge_done;
            type_prev_reg <= input_type_done;
            lim_prev_reg <= limit_event;
            oth_prev_reg <= other_fault;
        end
    end
    // Latch faults until read; set wins over read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chg_fault_reg <= 1'b0;
            other_fault_reg <= 1'b0;
            fault_pending_reg <= 1'b0;
        end else begin
            chg_fault_reg <= input_overvoltage_raw || (chg_fault_reg && !hif.fault_read);
            other_fault_reg <= other_fault || (other_fault_reg && !hif.fault_read);
            fault_pending_reg <= fault_new || (fault_pending_reg && !hif.fault_read);
        end
    end
    // Single byte read only: one read strobe per access
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hif.fault_register <= 8'h0;
        end else begin
            hif.fault_register <= {other_fault_reg, boost_fault_reg, 1'b0, // Boost flag clears on enable request
                                   chg_fault_reg ? `BSS_CHG_FAULT_INPUT : `BSS_CHG_FAULT_NONE,
                                   thermistor_fault_in}; // Live thermistor field
        end
    end
    // Pulse generator: faults suppressed while history unread
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_cnt_reg <= 32'h0;
            hif.host_irq_n <= 1'b1;
        end else if (irq_cnt_reg != 32'h0) begin
            irq_cnt_reg <= irq_cnt_reg - 32'h1;
            hif.host_irq_n <= (irq_cnt_reg == 32'h1);
        end else if (status_event || (fault_new && !fault_pending_reg)) begin
            irq_cnt_reg <= 32'(`BSS_IRQ_PULSE_CYC);
            hif.host_irq_n <= 1'b0;
        end
    end

    // ----------------------------------------
    // Status pin with blink
    // ----------------------------------------
    logic [31:0] blink_cnt_reg;
    logic blink_reg;
    logic suspended;
    assign suspended = input_overvoltage_raw || system_overvoltage || (thermistor_fault_in != 3'h0);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= 1'b0;
        end else if (blink_cnt_reg == 32'(`BSS_BLINK_HALF_CYC - 1)) begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= !blink_reg; // 1Hz square
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_pin_oe <= 1'b0;
        end else if (hif.charge_indicator_func_sel == `BSS_IND_DISABLED) begin
            stat_pin_oe <= 1'b0;
        end else if (suspended) begin
            stat_pin_oe <= blink_reg;
        end else begin
            stat_pin_oe <= charging && !charge_done;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_pin_o <= 1'b0;
        end else begin
            stat_pin_o <= 1'b0; // Open drain pulls low only
        end
    end
endmodule

// ---- hw/bss_host.sv ----
// Host end: command bits, push button and fault read strobe
`timescale 1ns/1ps
`include "bss_params.svh"
module bss_host (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link to device
    bss_if.host dif,
    // User commands (one-cycle pulses unless noted)
    input wire logic ship_req,
    input wire logic ship_delayed,
    input wire logic ship_exit_req,
    input wire logic power_cycle_req,
    input wire logic reg_reset_req,
    input wire logic highz_clear_req,
    input wire logic boost_on_req,
    input wire logic boost_off_req,
    input wire logic read_faults_req,
    input wire logic button_pressed,
    input wire logic reset_en_level,
    input wire logic [1:0] ovp_sel_level,
    input wire logic [1:0] ind_sel_level,
    // User status
    output logic irq_seen,
    output logic [7:0] fault_history,
    output logic [7:0] fault_current
);
    import bss_pkg::*;

    // ----------------------------------------
    // Command bits toward device
    // ----------------------------------------
    logic cycle_pend_reg; // Second half of host power cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dif.battery_switch_disable <= 1'b0;
            dif.ship_entry_delay_sel <= 1'b0;
            cycle_pend_reg <= 1'b0;
        end else if (power_cycle_req) begin
            dif.battery_switch_disable <= 1'b1; // Set then clear
            dif.ship_entry_delay_sel <= 1'b0;
            cycle_pend_reg <= 1'b1;
        end else if (cycle_pend_reg) begin
            dif.battery_switch_disable <= 1'b0;
            cycle_pend_reg <= 1'b0;
        end else if (ship_req) begin
            dif.battery_switch_disable <= 1'b1;
            dif.ship_entry_delay_sel <= ship_delayed;
        end else if (ship_exit_req || reg_reset_req) begin
            dif.battery_switch_disable <= 1'b0;
        end
    end
    // Strobes and levels
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dif.register_reset <= 1'b0;
            dif.input_highz_clear <= 1'b0;
            dif.boost_enable_req <= 1'b0;
            dif.boost_enable_clr_req <= 1'b0;
            dif.switch_reset_enable <= 1'b1;
            dif.input_overvoltage_sel <= `BSS_OVP_DEFAULT;
            dif.charge_indicator_func_sel <= 2'h0;
            dif.quick_on_button_n <= 1'b1;
        end else begin
            dif.register_reset <= reg_reset_req;
            dif.input_highz_clear <= highz_clear_req;
            dif.boost_enable_req <= boost_on_req;
            dif.boost_enable_clr_req <= boost_off_req;
            dif.switch_reset_enable <= reset_en_level;
            dif.input_overvoltage_sel <= ovp_sel_level;
            dif.charge_indicator_func_sel <= ind_sel_level;
            dif.quick_on_button_n <= !button_pressed; // Held for the press time
        end
    end

    // ----------------------------------------
    // Double fault read: history then current
    // ----------------------------------------
    logic [1:0] rd_step_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_step_reg <= 2'h0;
            dif.fault_read <= 1'b0;
            fault_history <= 8'h0;
            fault_current <= 8'h0;
        end else begin
            dif.fault_read <= 1'b0;
            unique case (rd_step_reg)
                2'h0: if (read_faults_req) rd_step_reg <= 2'h1;
                2'h1: begin
                    fault_history <= dif.fault_register;
                    dif.fault_read <= 1'b1;
                    rd_step_reg <= 2'h2;
                end
                2'h2: if (!dif.fault_read) rd_step_reg <= 2'h3; // Gap lets the read-clear show
                2'h3: begin
                    fault_current <= dif.fault_register;
                    dif.fault_read <= 1'b1;
                    rd_step_reg <= 2'h0;
                end
                default: rd_step_reg <= 2'h0;
            endcase
        end
    end
    // Interrupt seen flag
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_seen <= 1'b0;
        end else begin
            irq_seen <= !dif.host_irq_n;
        end
    end
endmodule

// ---- bench/bss_chk.sv ----
// Checker for the link between the device and host ends
`timescale 1ns/1ps
module bss_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Host command bits
    input wire logic battery_switch_disable,
    input wire logic ship_entry_delay_sel,
    input wire logic input_highz_clear,
    input wire logic boost_enable_req,
    input wire logic fault_read,
    // Device status
    input wire logic host_irq_n,
    input wire logic input_highz_enable,
    input wire logic boost_output_enable,
    input wire logic [7:0] fault_register,
    input wire logic battery_switch_on
);
    logic [16:0] low_reg; // Cycles the interrupt has been low
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Interrupt low-time counter
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) low_reg <= 17'h0;
        else low_reg <= host_irq_n ? 17'h0 : low_reg + 17'h1;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_ship_now; $rose(battery_switch_disable) && !ship_entry_delay_sel |-> ##[1:3] !battery_switch_on; endproperty
    property p_ship_dly; $rose(battery_switch_disable) && ship_entry_delay_sel |=> battery_switch_on[*8]; endproperty
    property p_hiz_boost; input_highz_enable && !boost_output_enable |=> !boost_output_enable; endproperty
    property p_irq_len; $rose(host_irq_n) |-> low_reg == 17'hc800; endproperty
    property p_irq_max; !host_irq_n |-> low_reg < 17'hc800; endproperty
    property p_fault_hold; $fell(fault_register[7]) || $fell(fault_register[3]) |-> $past(fault_read) ||
        $past(fault_read, 2) || $past(fault_read, 3); endproperty
    property p_boost_clr; boost_enable_req && !input_highz_enable |-> ##[1:2] !fault_register[6]; endproperty
    property p_hiz_clr; input_highz_clear |-> ##[1:2] !input_highz_enable; endproperty
    a_ship_now: assert property (p_ship_now) else $error("switch stayed on after disable");
    a_ship_dly: assert property (p_ship_dly) else $error("delayed entry opened switch early");
    a_hiz_boost: assert property (p_hiz_boost) else $error("boost enabled while high-z set");
    a_irq_len: assert property (p_irq_len) else $error("interrupt pulse length wrong");
    a_irq_max: assert property (p_irq_max) else $error("interrupt pulse too long");
    a_fault_hold: assert property (p_fault_hold) else $error("fault bit cleared without read");
    a_boost_clr: assert property (p_boost_clr) else $error("boost flag not cleared");
    a_hiz_clr: assert property (p_hiz_clr) else $error("high-z enable not cleared");
    // Main scenarios reached
    c_ship: cover property ($fell(battery_switch_on));
    c_irq: cover property ($rose(host_irq_n));
    c_boost: cover property ($rose(fault_register[6]));
endmodule

// ---- bench/tb_battery_switch_ship_status_ctrl.sv ----
// Self-checking bench joining the device and host ends
`timescale 1ns/1ps
module tb_battery_switch_ship_status_ctrl;
    // Drive: 0 ship, 1 exit, 2 reg reset, 3 high-z clear, 4 boost on, 5 boost off, 6 read, 7 retry, 8 cycle
    logic [8:0] pul = 9'h0;
    wire ship_req = pul[0], ship_exit_req = pul[1], reg_reset_req = pul[2], highz_clear_req = pul[3];
    wire boost_on_req = pul[4], boost_off_req = pul[5], read_faults_req = pul[6], boost_retry_done = pul[7];
    wire power_cycle_req = pul[8];
    logic clock = 1'b0, rst_n = 1'b0, ship_delayed = 1'b0, button_pressed = 1'b0, reset_en_level = 1'b1;
    logic vbus_present = 1'b0, vbus_in_range = 1'b0, vbus_above_bat_sleep = 1'b0, vbus_not_poor = 1'b0;
    logic input_type_done = 1'b0, input_overvoltage_raw = 1'b0, system_overvoltage = 1'b0, boost_short = 1'b0;
    logic charging = 1'b0, charge_done = 1'b0, limit_event = 1'b0, limit_irq_mask = 1'b0, other_fault = 1'b0;
    logic [1:0] ovp_sel_level = 2'h3, ind_sel_level = 2'h0;
    logic [2:0] thermistor_fault_in = 3'h0;
    // Design outputs
    logic irq_seen, battery_switch_gate, converter_stop, sys_sink_enable, stat_pin_o, stat_pin_oe;
    logic [7:0] fault_history, fault_current;
    int err_total = 0;
    int num_checks = 0;
    bss_if bif ();
    bss_device bss_device_i (.*, .hif(bif.device));
    bss_host bss_host_i (.*, .dif(bif.host));
    bss_chk bss_chk_i (.clock(clock), .rst_n(rst_n), .battery_switch_disable(bif.battery_switch_disable),
        .ship_entry_delay_sel(bif.ship_entry_delay_sel), .input_highz_clear(bif.input_highz_clear),
        .boost_enable_req(bif.boost_enable_req), .fault_read(bif.fault_read), .host_irq_n(bif.host_irq_n),
        .input_highz_enable(bif.input_highz_enable), .boost_output_enable(bif.boost_output_enable),
        .fault_register(bif.fault_register), .battery_switch_on(bif.battery_switch_on));
    // 200 MHz clock
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask
    // One-cycle user pulse, then settle
    task automatic pulse(input int b);
        pul[b] <= 1'b1;
        tk(1);
        pul[b] <= 1'b0;
        tk(5);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Clear the disable bit, then set it again
    task automatic ship(input logic dly, input logic [7:0] exp);
        ship_delayed <= dly;
        pulse(1);
        pulse(0);
        chk("gate in ship", exp, {7'h0, battery_switch_gate});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial begin
        tk(80000);
        err_total++;
        stop_test();
    end
    initial begin
        tk(8);
        rst_n <= 1'b1;
        tk(2);
        ship(1'b0, 8'h0);
        {vbus_present, vbus_in_range} <= 2'h3;
        tk(4);
        chk("gate on vbus", 8'h1, {7'h0, battery_switch_gate});
        ship(1'b0, 8'h0);
        pulse(2);
        chk("gate reg reset", 8'h1, {7'h0, battery_switch_gate});
        ship(1'b0, 8'h0);
        pulse(1);
        chk("gate clear", 8'h1, {7'h0, battery_switch_gate});
        ship(1'b1, 8'h1);
        pulse(1);
        pulse(3);
        $display("ship tests done");
        {vbus_above_bat_sleep, vbus_not_poor, input_type_done} <= 3'h7;
        tk(4);
        chk("power good", 8'h3, {6'h0, irq_seen, bif.power_good_flag});
        input_type_done <= 1'b0;
        tk(4);
        chk("power good", 8'h0, {7'h0, bif.power_good_flag});
        charging <= 1'b1;
        tk(4);
        chk("stat charging", 8'h1, {6'h0, stat_pin_o, stat_pin_oe});
        ind_sel_level <= 2'h3;
        tk(4);
        chk("stat off", 8'h0, {7'h0, stat_pin_oe});
        {ind_sel_level, charging, charge_done} <= 4'h1;
        tk(4);
        chk("stat done", 8'h0, {7'h0, stat_pin_oe});
        for (int i = 0; i < 4; i++) begin
            ovp_sel_level <= i[1:0];
            tk(3);
            chk("ovp select", i[7:0], {6'h0, bif.input_overvoltage_sel});
        end
        $display("status tests done");
        pulse(6);
        pulse(6);
        {thermistor_fault_in, input_overvoltage_raw} <= 4'hb;
        tk(4);
        chk("stop on ov", 8'h1, {7'h0, converter_stop});
        chk("thermistor", 8'h5, {5'h0, bif.fault_register[2:0]});
        {thermistor_fault_in, input_overvoltage_raw} <= 4'h0;
        pulse(6);
        chk("history ov", 8'h1, {6'h0, fault_history[4:3]});
        chk("thermistor", 8'h0, {5'h0, bif.fault_register[2:0]});
        pulse(6);
        chk("current ov", 8'h0, {6'h0, fault_current[4:3]});
        system_overvoltage <= 1'b1;
        tk(4);
        chk("sys ov", 8'h3, {6'h0, sys_sink_enable, converter_stop});
        system_overvoltage <= 1'b0;
        pulse(4);
        boost_short <= 1'b1;
        repeat (6) pulse(7);
        chk("boost retry", 8'h1, {7'h0, bif.boost_output_enable});
        pulse(7);
        chk("boost fault", 8'h40, bif.fault_register & 8'h40 | {7'h0, bif.boost_output_enable});
        boost_short <= 1'b0;
        pulse(4);
        chk("boost fault", 8'h0, bif.fault_register & 8'h40);
        pulse(5);
        $display("fault tests done");
        {vbus_present, vbus_in_range, reset_en_level} <= 3'h0;
        pulse(8);
        tk(20);
        chk("cycle back on", 8'h1, {7'h0, battery_switch_gate});
        chk("reset enable", 8'h0, {7'h0, bif.switch_reset_enable});
        for (int i = 0; i < 60000 && bif.host_irq_n !== 1'b1; i++) tk(1);
        chk("irq idle", 8'h1, {7'h0, bif.host_irq_n});
        $display("power tests done");
        stop_test();
    end
endmodule
